// ==== inc/pkt_pkg.sv ====
package pkt_pkg;
	localparam int CLK_MHZ = 100;
	localparam int MAX_LEN = 22;
	localparam int PING_MAX = 16;
	localparam int VER_LEN = 16;
	localparam int FLASH_LEN = 16;
	localparam int KEY_LEN = 1;
	localparam int FAN_LEN = 4;
	localparam int TEMP_LEN = 3;
	localparam int NUM_FANS = 4;
	localparam int NUM_TEMPS = 32;
	localparam int IDXW = 5;
	localparam int FIFO_DEPTH = 4;
	localparam logic [1:0] CLS_CMD = 2'h0;
	localparam logic [1:0] CLS_RESP = 2'h1;
	localparam logic [1:0] CLS_RPT = 2'h2;
	localparam logic [1:0] CLS_ERR = 2'h3;
	localparam logic [5:0] CODE_PING = 6'h00;
	localparam logic [5:0] CODE_VER = 6'h01;
	localparam logic [5:0] CODE_FLASH_WR = 6'h02;
	localparam logic [5:0] CODE_FLASH_RD = 6'h03;
	localparam logic [5:0] CODE_STORE_BOOT = 6'h04;
	localparam logic [5:0] CODE_RPT_KEY = 6'h00;
	localparam logic [5:0] CODE_RPT_FAN = 6'h01;
	localparam logic [5:0] CODE_RPT_TEMP = 6'h02;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_XOROUT = 16'hFFFF;
	localparam int ACK_LIMIT_US = 250000;
	localparam int ACK_LIMIT_CYC = ACK_LIMIT_US * CLK_MHZ;
	localparam int FAN_SLOT_US = 125000;
	localparam int FAN_SLOT_CYC = FAN_SLOT_US * CLK_MHZ;
	localparam int TEMP_PERIOD_US = 1000000;
	localparam int TEMP_SLOT_CYC = TEMP_PERIOD_US * CLK_MHZ / NUM_TEMPS;
	// Arbitrary identification string, sixteen ASCII bytes.
	localparam logic [8*VER_LEN-1:0] VERSION_ID = "MODULE0:h1.0,v10";

	typedef struct packed {
		logic [1:0] cls;
		logic [5:0] code;
	} pkt_type_t;

	typedef struct packed {
		pkt_type_t ptype;
		logic [7:0] len;
	} pkt_hdr_t;

	typedef enum {SRC_NONE, SRC_RX, SRC_VER, SRC_FLASH, SRC_RPT} src_t;

	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc_byte
endpackage : pkt_pkg

// ==== logic/crc_packet_command_protocol.sv ====
// Overview of operation
// - Packet is type, length, payload, check value.
// - Type byte: two class bits, six code bits.
// - Length byte counts payload, zero to 22.
// - CRC16 covers type, length and payload.
// - CRC low byte first, right after payload.
// - Acknowledge every packet within 250 ms; frames failing the CRC or the length check get no reply here.
// - Enabled key events send report 0x80.
// - Selected fans reported as 0x81 each half second.
// - Fan report: index, cycles, ticks high, low.
// - Selected sensors reported as 0x82 each second.
// - One reply per command, same code bits.
// - Valid structure, illegal content gets error class.
// - Ping echoes length and payload, type 0x40.
// - Version query returns sixteen ASCII bytes.
// - Flash write takes sixteen bytes, empty reply.
// - Flash read returns the stored sixteen bytes.
// - Code 4 saves boot configuration, empty reply.
// - Reporting, fail-safe, watchdog not saved at boot.
// - Link runs 115200 baud, 8N1.

module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	logic push;
	logic pop;

	assign inReady = (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]) || (wrPtr_r[AW] == rdPtr_r[AW]);
	assign outValid = wrPtr_r != rdPtr_r;
	assign outData = mem[rdPtr_r[AW-1:0]];
	assign push = ce && inValid && inReady;
	assign pop = ce && outValid && outReady;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
		end
	end
endmodule : sync_fifo

module crc_packet_command_protocol #(
	parameter int ACK_LIMIT_CYC = pkt_pkg::ACK_LIMIT_CYC,
	parameter int FAN_SLOT_CYC = pkt_pkg::FAN_SLOT_CYC,
	parameter int TEMP_SLOT_CYC = pkt_pkg::TEMP_SLOT_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	input wire logic keyEvent,
	input wire logic [7:0] keyCode,
	input wire logic keyReportEnable,
	input wire logic [pkt_pkg::NUM_FANS-1:0] fanReportMask,
	input wire logic [pkt_pkg::NUM_FANS-1:0][7:0] fanPulseCycleCount,
	input wire logic [pkt_pkg::NUM_FANS-1:0][15:0] fanTimerTicks,
	input wire logic [pkt_pkg::NUM_TEMPS-1:0] tempReportMask,
	input wire logic [pkt_pkg::NUM_TEMPS-1:0][15:0] tempValue,
	output logic [pkt_pkg::FLASH_LEN-1:0][7:0] userFlashData,
	output logic userFlashWrite,
	output logic storeBootState,
	output logic ackOverdue
);
	typedef enum {R_TYPE, R_LEN, R_DATA, R_CRCL, R_CRCH, R_HOLD} rx_state_t;
	typedef enum {T_IDLE, T_TYPE, T_LEN, T_DATA, T_CRCL, T_CRCH} tx_state_t;
	localparam int FANW = $clog2(FAN_SLOT_CYC);
	localparam int TEMPW = $clog2(TEMP_SLOT_CYC);
	localparam int ACKW = $clog2(ACK_LIMIT_CYC + 1);

	rx_state_t rxState_r;
	pkt_pkg::pkt_hdr_t rxHdr_r;
	logic [7:0] rxBuf_r [pkt_pkg::MAX_LEN];
	logic [pkt_pkg::IDXW-1:0] rxIdx_r;
	logic [15:0] rxCrc_r;
	logic [7:0] rxCrcLo_r;
	logic rxTake;

	tx_state_t txState_r;
	pkt_pkg::pkt_hdr_t txHdr_r;
	pkt_pkg::src_t txSrc_r;
	logic [pkt_pkg::IDXW-1:0] txIdx_r;
	logic [15:0] txCrc_r;
	logic [15:0] txCrcOut;
	logic txIsResp_r;
	logic [7:0] rptBuf_r [pkt_pkg::FAN_LEN];
	logic [7:0] pushByte;
	logic pushValid;
	logic pushReady;
	logic pushTake;
	logic respLoad;
	logic rptLoad;
	logic cmdDone;

	pkt_pkg::pkt_hdr_t respHdr;
	pkt_pkg::src_t respSrc;
	logic cmdLegal;

	logic keyPend_r;
	logic [7:0] keyCode_r;
	logic [pkt_pkg::NUM_FANS-1:0] fanPend_r;
	logic [pkt_pkg::NUM_TEMPS-1:0] tempPend_r;
	logic [FANW-1:0] fanTimer_r;
	logic [1:0] fanSlot_r;
	logic [TEMPW-1:0] tempTimer_r;
	logic [4:0] tempSlot_r;
	logic [ACKW-1:0] ackCount_r;
	logic fanSel;
	logic [1:0] fanIdx;
	logic tempSel;
	logic [4:0] tempIdx;

	assign rxReady = rxState_r != R_HOLD;
	// Line framing at 115200 baud 8N1 sits outside; bytes arrive here whole.
	assign rxTake = ce && rxValid && rxReady;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxState_r <= R_TYPE;
			rxHdr_r <= '0;
			rxIdx_r <= '0;
			rxCrc_r <= pkt_pkg::CRC_INIT;
			rxCrcLo_r <= 8'h00;
		end else if (ce) begin
			unique case (rxState_r)
				R_TYPE: if (rxTake) begin
					rxHdr_r.ptype <= rxData;
					rxCrc_r <= pkt_pkg::crc_byte(pkt_pkg::CRC_INIT, rxData);
					rxState_r <= R_LEN;
				end
				R_LEN: if (rxTake) begin
					rxHdr_r.len <= rxData;
					rxCrc_r <= pkt_pkg::crc_byte(rxCrc_r, rxData);
					rxIdx_r <= '0;
					if (rxData > 8'(pkt_pkg::MAX_LEN)) begin
						rxState_r <= R_TYPE;
					end else begin
						rxState_r <= (rxData == 8'h00) ? R_CRCL : R_DATA;
					end
				end
				R_DATA: if (rxTake) begin
					rxCrc_r <= pkt_pkg::crc_byte(rxCrc_r, rxData);
					rxIdx_r <= rxIdx_r + 1'b1;
					if ({3'h0, rxIdx_r} == rxHdr_r.len - 8'h01) begin
						rxState_r <= R_CRCL;
					end
				end
				R_CRCL: if (rxTake) begin
					rxCrcLo_r <= rxData;
					rxState_r <= R_CRCH;
				end
				R_CRCH: if (rxTake) begin
					// A corrupted frame is dropped without reply; hunting resumes at the next byte.
					rxState_r <= ({rxData, rxCrcLo_r} == (rxCrc_r ^ pkt_pkg::CRC_XOROUT))
						? R_HOLD : R_TYPE;
				end
				R_HOLD: if (cmdDone) begin
					rxState_r <= R_TYPE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rxTake && rxState_r == R_DATA) begin
			rxBuf_r[rxIdx_r] <= rxData;
		end
	end

	always_comb begin
		cmdLegal = 1'b0;
		respSrc = pkt_pkg::SRC_NONE;
		respHdr.ptype.code = rxHdr_r.ptype.code;
		respHdr.len = 8'h00;
		if (rxHdr_r.ptype.cls == pkt_pkg::CLS_CMD) begin
			unique case (rxHdr_r.ptype.code)
				pkt_pkg::CODE_PING: if (rxHdr_r.len <= 8'(pkt_pkg::PING_MAX)) begin
					cmdLegal = 1'b1;
					respSrc = pkt_pkg::SRC_RX;
					respHdr.len = rxHdr_r.len;
				end
				pkt_pkg::CODE_VER: if (rxHdr_r.len == 8'h00) begin
					cmdLegal = 1'b1;
					respSrc = pkt_pkg::SRC_VER;
					respHdr.len = 8'(pkt_pkg::VER_LEN);
				end
				pkt_pkg::CODE_FLASH_WR: cmdLegal = rxHdr_r.len == 8'(pkt_pkg::FLASH_LEN);
				pkt_pkg::CODE_FLASH_RD: if (rxHdr_r.len == 8'h00) begin
					cmdLegal = 1'b1;
					respSrc = pkt_pkg::SRC_FLASH;
					respHdr.len = 8'(pkt_pkg::FLASH_LEN);
				end
				pkt_pkg::CODE_STORE_BOOT: cmdLegal = rxHdr_r.len == 8'h00;
				default: cmdLegal = 1'b0;
			endcase
		end
		if (!cmdLegal) begin
			respSrc = pkt_pkg::SRC_NONE;
			respHdr.len = 8'h00;
		end
		respHdr.ptype.cls = cmdLegal ? pkt_pkg::CLS_RESP : pkt_pkg::CLS_ERR;
	end

	always_comb begin
		fanSel = 1'b0;
		fanIdx = 2'h0;
		for (int i = pkt_pkg::NUM_FANS - 1; i >= 0; i--) begin
			if (fanPend_r[i]) begin
				fanSel = 1'b1;
				fanIdx = 2'(i);
			end
		end
		tempSel = 1'b0;
		tempIdx = 5'h00;
		for (int i = pkt_pkg::NUM_TEMPS - 1; i >= 0; i--) begin
			if (tempPend_r[i]) begin
				tempSel = 1'b1;
				tempIdx = 5'(i);
			end
		end
	end

	// Replies take priority over reports so a report burst cannot starve the acknowledgement.
	assign respLoad = ce && txState_r == T_IDLE && rxState_r == R_HOLD;
	assign rptLoad = ce && txState_r == T_IDLE && !respLoad && (keyPend_r || fanSel || tempSel);
	assign cmdDone = pushTake && txState_r == T_CRCH && txIsResp_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txState_r <= T_IDLE;
			txHdr_r <= '0;
			txSrc_r <= pkt_pkg::SRC_NONE;
			txIdx_r <= '0;
			txCrc_r <= pkt_pkg::CRC_INIT;
			txIsResp_r <= 1'b0;
			for (int i = 0; i < pkt_pkg::FAN_LEN; i++) begin
				rptBuf_r[i] <= 8'h00;
			end
		end else if (ce) begin
			if (respLoad) begin
				txHdr_r <= respHdr;
				txSrc_r <= respSrc;
				txIsResp_r <= 1'b1;
				txState_r <= T_TYPE;
			end else if (rptLoad) begin
				txHdr_r.ptype.cls <= pkt_pkg::CLS_RPT;
				txSrc_r <= pkt_pkg::SRC_RPT;
				txIsResp_r <= 1'b0;
				txState_r <= T_TYPE;
				if (keyPend_r) begin
					txHdr_r.ptype.code <= pkt_pkg::CODE_RPT_KEY;
					txHdr_r.len <= 8'(pkt_pkg::KEY_LEN);
					rptBuf_r[0] <= keyCode_r;
				end else if (fanSel) begin
					txHdr_r.ptype.code <= pkt_pkg::CODE_RPT_FAN;
					txHdr_r.len <= 8'(pkt_pkg::FAN_LEN);
					rptBuf_r[0] <= {6'h00, fanIdx};
					rptBuf_r[1] <= fanPulseCycleCount[fanIdx];
					rptBuf_r[2] <= fanTimerTicks[fanIdx][15:8];
					rptBuf_r[3] <= fanTimerTicks[fanIdx][7:0];
				end else begin
					txHdr_r.ptype.code <= pkt_pkg::CODE_RPT_TEMP;
					txHdr_r.len <= 8'(pkt_pkg::TEMP_LEN);
					rptBuf_r[0] <= {3'h0, tempIdx};
					rptBuf_r[1] <= tempValue[tempIdx][15:8];
					rptBuf_r[2] <= tempValue[tempIdx][7:0];
				end
			end else if (pushTake) begin
				unique case (txState_r)
					T_TYPE: begin
						txCrc_r <= pkt_pkg::crc_byte(pkt_pkg::CRC_INIT, pushByte);
						txState_r <= T_LEN;
					end
					T_LEN: begin
						txCrc_r <= pkt_pkg::crc_byte(txCrc_r, pushByte);
						txIdx_r <= '0;
						txState_r <= (txHdr_r.len == 8'h00) ? T_CRCL : T_DATA;
					end
					T_DATA: begin
						txCrc_r <= pkt_pkg::crc_byte(txCrc_r, pushByte);
						txIdx_r <= txIdx_r + 1'b1;
						if ({3'h0, txIdx_r} == txHdr_r.len - 8'h01) begin
							txState_r <= T_CRCL;
						end
					end
					T_CRCL: txState_r <= T_CRCH;
					T_CRCH: txState_r <= T_IDLE;
					default: txState_r <= T_IDLE;
				endcase
			end
		end
	end

	assign txCrcOut = txCrc_r ^ pkt_pkg::CRC_XOROUT;
	assign pushValid = txState_r != T_IDLE;
	assign pushTake = ce && pushValid && pushReady;

	always_comb begin
		pushByte = 8'h00;
		unique case (txState_r)
			T_TYPE: pushByte = txHdr_r.ptype;
			T_LEN: pushByte = txHdr_r.len;
			T_DATA: begin
				unique case (txSrc_r)
					pkt_pkg::SRC_RX: pushByte = rxBuf_r[txIdx_r];
					pkt_pkg::SRC_VER: pushByte = pkt_pkg::VERSION_ID[8*(pkt_pkg::VER_LEN-1-txIdx_r) +: 8];
					pkt_pkg::SRC_FLASH: pushByte = userFlashData[txIdx_r[3:0]];
					pkt_pkg::SRC_RPT: pushByte = rptBuf_r[txIdx_r[1:0]];
					pkt_pkg::SRC_NONE: pushByte = 8'h00;
				endcase
			end
			T_CRCL: pushByte = txCrcOut[7:0];
			T_CRCH: pushByte = txCrcOut[15:8];
			T_IDLE: pushByte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			userFlashData <= '0;
			userFlashWrite <= 1'b0;
			storeBootState <= 1'b0;
		end else if (ce) begin
			userFlashWrite <= 1'b0;
			storeBootState <= 1'b0;
			if (respLoad && cmdLegal && rxHdr_r.ptype.code == pkt_pkg::CODE_FLASH_WR) begin
				for (int i = 0; i < pkt_pkg::FLASH_LEN; i++) begin
					userFlashData[i] <= rxBuf_r[i];
				end
				userFlashWrite <= 1'b1;
			end
			// The snapshot pulse covers display and I/O settings only; report masks stay outside.
			if (respLoad && cmdLegal && rxHdr_r.ptype.code == pkt_pkg::CODE_STORE_BOOT) begin
				storeBootState <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			keyPend_r <= 1'b0;
			keyCode_r <= 8'h00;
		end else if (ce) begin
			// A new event in the load cycle wins over the clear.
			if (keyEvent && keyReportEnable) begin
				keyPend_r <= 1'b1;
				keyCode_r <= keyCode;
			end else if (rptLoad) begin
				keyPend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fanTimer_r <= '0;
			fanSlot_r <= 2'h0;
			fanPend_r <= '0;
		end else if (ce) begin
			logic [pkt_pkg::NUM_FANS-1:0] clr;
			logic [pkt_pkg::NUM_FANS-1:0] set;
			clr = '0;
			set = '0;
			if (rptLoad && !keyPend_r && fanSel) begin
				clr[fanIdx] = 1'b1;
			end
			if (fanTimer_r == FANW'(FAN_SLOT_CYC - 1)) begin
				fanTimer_r <= '0;
				fanSlot_r <= fanSlot_r + 1'b1;
				set[fanSlot_r] = fanReportMask[fanSlot_r];
			end else begin
				fanTimer_r <= fanTimer_r + 1'b1;
			end
			fanPend_r <= (fanPend_r & ~clr) | set;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tempTimer_r <= '0;
			tempSlot_r <= 5'h00;
			tempPend_r <= '0;
		end else if (ce) begin
			logic [pkt_pkg::NUM_TEMPS-1:0] clr;
			logic [pkt_pkg::NUM_TEMPS-1:0] set;
			clr = '0;
			set = '0;
			if (rptLoad && !keyPend_r && !fanSel) begin
				clr[tempIdx] = 1'b1;
			end
			if (tempTimer_r == TEMPW'(TEMP_SLOT_CYC - 1)) begin
				tempTimer_r <= '0;
				tempSlot_r <= tempSlot_r + 1'b1;
				set[tempSlot_r] = tempReportMask[tempSlot_r];
			end else begin
				tempTimer_r <= tempTimer_r + 1'b1;
			end
			tempPend_r <= (tempPend_r & ~clr) | set;
		end
	end

	// The reply itself leaves within a few cycles; only a stalled drain can make it late.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ackCount_r <= '0;
			ackOverdue <= 1'b0;
		end else if (ce) begin
			if (rxState_r != R_HOLD || cmdDone) begin
				ackCount_r <= '0;
			end else if (ackCount_r != ACKW'(ACK_LIMIT_CYC)) begin
				ackCount_r <= ackCount_r + 1'b1;
			end
			if (rxState_r == R_HOLD && ackCount_r == ACKW'(ACK_LIMIT_CYC - 1)) begin
				ackOverdue <= 1'b1;
			end else if (cmdDone) begin
				ackOverdue <= 1'b0;
			end
		end
	end

	sync_fifo #(
		.WIDTH(8),
		.DEPTH(pkt_pkg::FIFO_DEPTH)
	) txFifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.inData(pushByte),
		.inValid(pushValid),
		.inReady(pushReady),
		.outData(txData),
		.outValid(txValid),
		.outReady(txReady)
	);
endmodule : crc_packet_command_protocol

// ==== verif/crc_packet_command_protocol_sva.sv ====
module crc_packet_command_protocol_sva #(
	parameter int ACK_LIMIT_CYC = pkt_pkg::ACK_LIMIT_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic [pkt_pkg::FLASH_LEN-1:0][7:0] userFlashData,
	input wire logic userFlashWrite,
	input wire logic storeBootState,
	input wire logic ackOverdue
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int waitCnt_r;

	// Counts how long the block has held a command without finishing its reply.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt_r <= 0;
		end else if (rxReady) begin
			waitCnt_r <= 0;
		end else if (ce) begin
			waitCnt_r <= waitCnt_r + 1;
		end
	end

	chk_reset_idle: assert property (
		$rose(rst_n) |-> !txValid && rxReady)
		else $error("not idle after reset");
	chk_tx_hold: assert property (
		txValid && !txReady |=> txValid && $stable(txData))
		else $error("tx byte changed while stalled");
	chk_reply_start: assert property (
		$fell(rxReady) |-> ##[0:12] txValid)
		else $error("no reply byte after command");
	chk_overdue_time: assert property (
		$rose(ackOverdue) |-> waitCnt_r >= ACK_LIMIT_CYC - 3 && waitCnt_r <= ACK_LIMIT_CYC + 3)
		else $error("overdue flag at wrong time");
	chk_overdue_hold: assert property (
		ackOverdue && !rxReady |=> ackOverdue || rxReady)
		else $error("overdue flag dropped early");
	chk_overdue_idle: assert property (
		rxReady && !ackOverdue |=> !ackOverdue)
		else $error("overdue flag without command");
	chk_overdue_clear: assert property (
		$rose(rxReady) |-> ##[0:2] !ackOverdue)
		else $error("overdue flag not cleared");
	chk_ce_freeze: assert property (
		!ce |=> $stable(txData) && $stable(txValid) && $stable(rxReady))
		else $error("state moved while disabled");
	chk_flash_pulse: assert property (
		userFlashWrite |=> !userFlashWrite)
		else $error("flash write pulse too long");
	chk_boot_pulse: assert property (
		storeBootState |=> !storeBootState && !userFlashWrite)
		else $error("boot store pulse too long");
	chk_flash_stable: assert property (
		!userFlashWrite && !$past(userFlashWrite) |-> $stable(userFlashData))
		else $error("stored bytes changed without write");

	cover property ($rose(ackOverdue));
	cover property (userFlashWrite);
	cover property (storeBootState);
	cover property (txValid && !txReady);
endmodule : crc_packet_command_protocol_sva

bind crc_packet_command_protocol crc_packet_command_protocol_sva #(
	.ACK_LIMIT_CYC(ACK_LIMIT_CYC)
) u_sva (
	.mclk(mclk),
	.rst_n(rst_n),
	.ce(ce),
	.rxReady(rxReady),
	.txData(txData),
	.txValid(txValid),
	.txReady(txReady),
	.userFlashData(userFlashData),
	.userFlashWrite(userFlashWrite),
	.storeBootState(storeBootState),
	.ackOverdue(ackOverdue)
);

// ==== verif/host_model.sv ====
module host_model (
	input wire logic mclk,
	input wire logic rst_n,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] gotQ[$];
	int stampQ[$];
	int cyc = 0;
	bit stall = 1'b0;

	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
		txReady = 1'b1;
	end

	always @(negedge mclk) txReady <= !stall;

	// Every byte is queued at once, so a slow reader never loses a frame.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (rst_n && txValid === 1'b1 && txReady) begin
			gotQ.push_back(txData);
			stampQ.push_back(cyc);
		end
	end

	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = pkt_pkg::CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ pkt_pkg::CRC_POLY : c >> 1;
		end
		return c ^ pkt_pkg::CRC_XOROUT;
	endfunction : crc_of

	task automatic send_raw(input logic [7:0] b[$]);
		int w;
		foreach (b[i]) begin
			@(negedge mclk);
			rxData <= b[i];
			rxValid <= 1'b1;
			w = 0;
			while (rxReady !== 1'b1 && w < 500) begin
				@(negedge mclk);
				w++;
			end
		end
		@(negedge mclk);
		rxValid <= 1'b0;
		rxData <= ~b[b.size()-1];
	endtask : send_raw

	task automatic send_pkt(input logic [7:0] t, input logic [7:0] p[$], input bit bad);
		logic [7:0] f[$];
		logic [15:0] c;
		f = {t, 8'(p.size())};
		f = {f, p};
		c = crc_of(f);
		f.push_back(c[7:0] ^ {7'h00, bad});
		f.push_back(c[15:8]);
		send_raw(f);
	endtask : send_pkt

	task automatic get_pkt(output logic [7:0] t, output logic [7:0] p[$], output int stamp,
			output bit ok);
		logic [7:0] f[$];
		logic [15:0] c;
		int n;
		int w;
		ok = 1'b0;
		p = {};
		t = 8'h00;
		stamp = 0;
		w = 0;
		while (gotQ.size() < 2 || gotQ.size() < gotQ[1] + 4) begin
			@(posedge mclk);
			w++;
			if (w > 3000) return;
		end
		stamp = stampQ[0];
		t = gotQ[0];
		n = gotQ[1];
		for (int i = 0; i < n + 2; i++) f.push_back(gotQ[i]);
		for (int i = 2; i < n + 2; i++) p.push_back(f[i]);
		c = crc_of(f);
		ok = gotQ[n+2] === c[7:0] && gotQ[n+3] === c[15:8];
		repeat (n + 4) begin
			void'(gotQ.pop_front());
			void'(stampQ.pop_front());
		end
	endtask : get_pkt

	task automatic flush;
		repeat (100) @(negedge mclk);
		gotQ.delete();
		stampQ.delete();
	endtask : flush
endmodule : host_model

// ==== verif/crc_packet_command_protocol_test.sv ====
module crc_packet_command_protocol_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ACK = 64;
	localparam int FAN = 16;
	localparam int TMP = 8;
	logic mclk = 1'b0;
	logic rst_n;
	logic ce;
	logic [7:0] rxData;
	logic rxValid;
	logic rxReady;
	logic [7:0] txData;
	logic txValid;
	logic txReady;
	logic keyEvent;
	logic [7:0] keyCode;
	logic keyReportEnable;
	logic [pkt_pkg::NUM_FANS-1:0] fanReportMask;
	logic [pkt_pkg::NUM_FANS-1:0][7:0] fanPulseCycleCount;
	logic [pkt_pkg::NUM_FANS-1:0][15:0] fanTimerTicks;
	logic [pkt_pkg::NUM_TEMPS-1:0] tempReportMask;
	logic [pkt_pkg::NUM_TEMPS-1:0][15:0] tempValue;
	logic [pkt_pkg::FLASH_LEN-1:0][7:0] userFlashData;
	logic userFlashWrite;
	logic storeBootState;
	logic ackOverdue;
	logic [7:0] q[$];
	logic [7:0] none[$];
	logic [7:0] ver[$];
	int err_count = 0;
	int n_compared = 0;
	int flashPulses = 0;
	int bootPulses = 0;
	int lastStamp;

	always #5 mclk = ~mclk;

	always @(posedge mclk) begin
		if (userFlashWrite === 1'b1) flashPulses++;
		if (storeBootState === 1'b1) bootPulses++;
	end

	crc_packet_command_protocol #(
		.ACK_LIMIT_CYC(ACK),
		.FAN_SLOT_CYC(FAN),
		.TEMP_SLOT_CYC(TMP)
	) u_dut (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.rxData(rxData),
		.rxValid(rxValid),
		.rxReady(rxReady),
		.txData(txData),
		.txValid(txValid),
		.txReady(txReady),
		.keyEvent(keyEvent),
		.keyCode(keyCode),
		.keyReportEnable(keyReportEnable),
		.fanReportMask(fanReportMask),
		.fanPulseCycleCount(fanPulseCycleCount),
		.fanTimerTicks(fanTimerTicks),
		.tempReportMask(tempReportMask),
		.tempValue(tempValue),
		.userFlashData(userFlashData),
		.userFlashWrite(userFlashWrite),
		.storeBootState(storeBootState),
		.ackOverdue(ackOverdue)
	);

	host_model u_host (
		.mclk(mclk),
		.rst_n(rst_n),
		.rxData(rxData),
		.rxValid(rxValid),
		.rxReady(rxReady),
		.txData(txData),
		.txValid(txValid),
		.txReady(txReady)
	);

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %b", $time, what, got);
		end
	endtask : chk1

	task automatic chkN(input int got, input int exp, input string what);
		n_compared++;
		if (got != exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask : chkN

	task automatic expect_pkt(input logic [7:0] t, input logic [7:0] p[$]);
		logic [7:0] gt;
		logic [7:0] gp[$];
		bit ok;
		u_host.get_pkt(gt, gp, lastStamp, ok);
		chk1(ok, 1'b1, "reply check value");
		chk8(gt, t, "type");
		chkN(gp.size(), p.size(), "length");
		foreach (p[i]) if (i < gp.size()) chk8(gp[i], p[i], "payload");
	endtask : expect_pkt

	task automatic fill(input int n, input logic [7:0] base);
		q = {};
		for (int i = 0; i < n; i++) q.push_back(base + 8'(i));
	endtask : fill

	task automatic t_ping;
		int lens[3] = '{0, 1, 16};
		foreach (lens[k]) begin
			fill(lens[k], 8'hA0);
			u_host.send_pkt(8'h00, q, 1'b0);
			if (k == 1) begin
				ce <= 1'b0;
				repeat (5) @(negedge mclk);
				ce <= 1'b1;
			end
			expect_pkt(8'h40, q);
		end
	endtask : t_ping

	task automatic t_cmds;
		int f0;
		int b0;
		u_host.send_pkt(8'h01, none, 1'b0);
		expect_pkt(8'h41, ver);
		f0 = flashPulses;
		fill(16, 8'h30);
		u_host.send_pkt(8'h02, q, 1'b0);
		expect_pkt(8'h42, none);
		chkN(flashPulses - f0, 1, "flash write pulse");
		foreach (q[i]) chk8(userFlashData[i], q[i], "stored byte");
		u_host.send_pkt(8'h03, none, 1'b0);
		expect_pkt(8'h43, q);
		b0 = bootPulses;
		u_host.send_pkt(8'h04, none, 1'b0);
		expect_pkt(8'h44, none);
		chkN(bootPulses - b0, 1, "boot store pulse");
	endtask : t_cmds

	task automatic t_illegal;
		logic [7:0] types[6] = '{8'h04, 8'h02, 8'h01, 8'h09, 8'h85, 8'h00};
		int lens[6] = '{1, 15, 1, 0, 0, 17};
		int f0;
		int b0;
		f0 = flashPulses;
		b0 = bootPulses;
		foreach (types[k]) begin
			fill(lens[k], 8'h55);
			u_host.send_pkt(types[k], q, 1'b0);
			expect_pkt({2'h3, types[k][5:0]}, none);
		end
		chkN(flashPulses + bootPulses - f0 - b0, 0, "side effect");
		chk8(userFlashData[0], 8'h30, "stored byte kept");
	endtask : t_illegal

	task automatic t_drop;
		fill(2, 8'h66);
		u_host.send_pkt(8'h00, q, 1'b1);
		q = {8'h00, 8'h17};
		u_host.send_raw(q);
		fill(3, 8'h77);
		u_host.send_pkt(8'h00, q, 1'b0);
		expect_pkt(8'h40, q);
		repeat (50) @(negedge mclk);
		chkN(u_host.gotQ.size(), 0, "reply to dropped frame");
	endtask : t_drop

	task automatic key_press(input logic [7:0] c);
		@(negedge mclk);
		keyCode <= c;
		keyEvent <= 1'b1;
		@(negedge mclk);
		keyEvent <= 1'b0;
	endtask : key_press

	task automatic t_reports;
		int s0;
		key_press(8'h21);
		repeat (30) @(negedge mclk);
		chkN(u_host.gotQ.size(), 0, "masked key report");
		keyReportEnable <= 1'b1;
		key_press(8'h22);
		q = {8'h22};
		expect_pkt(8'h80, q);
		@(negedge mclk);
		fanReportMask <= 4'h4;
		q = {8'h02, fanPulseCycleCount[2], fanTimerTicks[2][15:8], fanTimerTicks[2][7:0]};
		expect_pkt(8'h81, q);
		s0 = lastStamp;
		expect_pkt(8'h81, q);
		chkN(lastStamp - s0, 4 * FAN, "fan report period");
		@(negedge mclk);
		fanReportMask <= 4'h0;
		u_host.flush();
		tempReportMask <= 32'h0000_0020;
		q = {8'h05, tempValue[5][15:8], tempValue[5][7:0]};
		expect_pkt(8'h82, q);
		s0 = lastStamp;
		expect_pkt(8'h82, q);
		chkN(lastStamp - s0, pkt_pkg::NUM_TEMPS * TMP, "sensor report period");
		@(negedge mclk);
		tempReportMask <= 32'h0000_0000;
		u_host.flush();
	endtask : t_reports

	// The sink stalls long enough that a sixteen byte reply cannot fit the buffer.
	task automatic t_overdue;
		u_host.stall = 1'b1;
		u_host.send_pkt(8'h01, none, 1'b0);
		repeat (ACK + 10) @(negedge mclk);
		chk1(ackOverdue, 1'b1, "overdue flag");
		chk1(rxReady, 1'b0, "command held");
		chk1(txValid, 1'b1, "buffer holds bytes");
		u_host.stall = 1'b0;
		expect_pkt(8'h41, ver);
		repeat (3) @(negedge mclk);
		chk1(ackOverdue, 1'b0, "overdue cleared");
		chk1(txValid, 1'b0, "buffer drained");
	endtask : t_overdue

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		keyEvent = 1'b0;
		keyCode = 8'h00;
		keyReportEnable = 1'b0;
		fanReportMask = 4'h0;
		tempReportMask = 32'h0000_0000;
		for (int i = 0; i < pkt_pkg::NUM_FANS; i++) begin
			fanPulseCycleCount[i] = 8'h10 + 8'(i);
			fanTimerTicks[i] = 16'hA5C0 + 16'(i);
		end
		for (int i = 0; i < pkt_pkg::NUM_TEMPS; i++) tempValue[i] = 16'h1200 + 16'(i);
		for (int i = pkt_pkg::VER_LEN - 1; i >= 0; i--) ver.push_back(pkt_pkg::VERSION_ID[8*i +: 8]);
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		t_ping();
		t_cmds();
		t_illegal();
		t_drop();
		t_reports();
		t_overdue();
		test_done();
	end

	initial begin
		repeat (30000) @(posedge mclk);
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end
endmodule : crc_packet_command_protocol_test
